// file: pic_top.sv
// Top of the PWM interrupt, fault and output control slice with its register port.
// How it works
// - Writing to a generator enable-set register sets chosen bits only.
// - Writing to a generator enable-clear register masks chosen sources.
// - Enables cover six interrupt events and four trigger events.
// - Module enable holds one bit per generator and per fault input.
// - Module status reads raw or masked, generators low, faults high.
// - Active period is counted in PWM clock ticks between zero pulses.
// - Period read returns the last written value, not the active one.
// - Several writes before an update leave only the latest pending.
// - A suppressed output is forced inactive while its fault is active.
// - Outputs without suppression keep their waveform during a fault.
// - Without extended handling a suppressed output is driven low.
// - With extended handling the level bit selects high or low.
// - The level bit does nothing on unsuppressed outputs.
// - Each output has an inversion bit.
// - Writing one to a generator status bit clears it.
module pic_top
  import pic_pkg::*;
(
  input  wire logic                      clk,
  input  wire logic                      rst_b,
  input  wire logic [AW-1:0]             addr,
  input  wire logic [DW-1:0]             wdata,
  input  wire logic                      wr,
  input  wire logic                      rd,
  output logic      [DW-1:0]             rdata,
  input  wire logic [NGEN-1:0][NEVT-1:0] gen_evt,
  input  wire logic [NGEN-1:0]           gen_fault,
  input  wire logic [NGEN-1:0]           fault_in,
  input  wire logic [NOUT-1:0]           wave,
  output logic      [NGEN-1:0]           gen_irq,
  output logic      [NGEN-1:0]           gen_trig,
  output logic      [NGEN-1:0][PERW-1:0] period_active,
  output logic                           mod_irq,
  output logic      [NOUT-1:0]           pwm_out
);

  typedef struct packed {
    logic [NMOD-1:0] men;
    logic [NGEN-1:0] fris;
    logic [NOUT-1:0] sup;
    logic [NOUT-1:0] lvl;
    logic [NOUT-1:0] inv;
    logic            ext;
    logic [DW-1:0]   rdata;
    logic            irq;
  } pic_top_s;

  pic_top_s s_q;
  pic_top_s s_d;

  // Decoded address fields.
  logic              in_gen;
  logic [GSEL_W-1:0] gsel;
  logic [GOFF_W-1:0] goff;
  logic [MOFF_W-1:0] moff;

  // Per-generator strobes and returned state.
  logic [NGEN-1:0]           g_en_set;
  logic [NGEN-1:0]           g_en_clr;
  logic [NGEN-1:0]           g_ris_clr;
  logic [NGEN-1:0]           g_per_wr;
  logic [NGEN-1:0][NEN-1:0]  g_en;
  logic [NGEN-1:0][NEVT-1:0] g_ris;
  logic [NGEN-1:0][PERW-1:0] g_pend;

  // Module status as seen by software.
  logic [NMOD-1:0] mod_raw;
  logic [NMOD-1:0] mod_raw_d;

  // Address split into region, generator and offset.
  assign in_gen = addr[GREG_BIT];
  assign gsel   = gen_of(addr);
  assign goff   = addr[GOFF_W-1:0];
  assign moff   = addr[MOFF_W-1:0];

  // Write strobes for the generator windows.
  always_comb begin
    g_en_set  = '0;
    g_en_clr  = '0;
    g_ris_clr = '0;
    g_per_wr  = '0;
    if (wr && in_gen) begin
      case (goff)
        G_EN_SET: begin
          g_en_set[gsel] = 1'b1;
        end
        G_EN_CLR: begin
          g_en_clr[gsel] = 1'b1;
        end
        G_RIS: begin
          g_ris_clr[gsel] = 1'b1;
        end
        G_PER: begin
          g_per_wr[gsel] = 1'b1;
        end
        default: begin
          g_per_wr = '0;
        end
      endcase
    end
  end

  // Four identical generator slices.
  for (genvar g = 0; g < NGEN; g++) begin : gen_slice
    pic_gen u_gen (
      .clk      (clk),
      .rst_b    (rst_b),
      .evt      (gen_evt[g]),
      .en_set   (g_en_set[g]),
      .en_clr   (g_en_clr[g]),
      .ris_clr  (g_ris_clr[g]),
      .per_wr   (g_per_wr[g]),
      .wdata    (wdata),
      .en       (g_en[g]),
      .ris      (g_ris[g]),
      .irq      (gen_irq[g]),
      .trig     (gen_trig[g]),
      .per_pend (g_pend[g]),
      .per_act  (period_active[g])
    );
  end

  // Output stage runs from the configuration held here.
  pic_outs u_outs (
    .clk       (clk),
    .rst_b     (rst_b),
    .wave      (wave),
    .gen_fault (gen_fault),
    .sup       (s_q.sup),
    .lvl       (s_q.lvl),
    .inv       (s_q.inv),
    .ext       (s_q.ext),
    .pwm_out   (pwm_out)
  );

  // raw status layout
  // Generator bits are the generators' own masked levels.
  assign mod_raw   = {s_q.fris, gen_irq};
  assign mod_raw_d = {s_d.fris, gen_irq};

  // Module registers, fault status and read data.
  always_comb begin
    s_d = s_q;
    // Fault capture; a fault in the clearing cycle survives the clear.
    if (wr && !in_gen && moff == M_RIS) begin
      s_d.fris = s_q.fris & ~wdata[FLT_LSB +: NGEN];
    end
    s_d.fris = s_d.fris | fault_in;
    if (wr && !in_gen) begin
      case (moff)
        M_EN_SET: begin
          s_d.men = s_q.men | wdata[NMOD-1:0];
        end
        M_EN_CLR: begin
          s_d.men = s_q.men & ~wdata[NMOD-1:0];
        end
        M_FSUP: begin
          s_d.sup = wdata[NOUT-1:0];
        end
        M_FLVL: begin
          s_d.lvl = wdata[NOUT-1:0];
        end
        M_INV: begin
          s_d.inv = wdata[NOUT-1:0];
        end
        M_EXTF: begin
          s_d.ext = wdata[0];
        end
        default: begin
          s_d.ext = s_q.ext;
        end
      endcase
    end
    s_d.irq = |(mod_raw_d & s_d.men);
    // Read data stands for exactly one cycle after the strobe.
    s_d.rdata = RD_ZERO;
    if (rd && in_gen) begin
      case (goff)
        G_EN: begin
          s_d.rdata[NEN-1:0] = g_en[gsel];
        end
        G_RIS: begin
          s_d.rdata[NEVT-1:0] = g_ris[gsel];
        end
        G_MIS: begin
          s_d.rdata[NEVT-1:0] = g_ris[gsel] & g_en[gsel][NEVT-1:0];
        end
        G_PER: begin
          s_d.rdata[PERW-1:0] = g_pend[gsel];
        end
        default: begin
          s_d.rdata = RD_ZERO;
        end
      endcase
    end else if (rd) begin
      case (moff)
        M_EN: begin
          s_d.rdata[NMOD-1:0] = s_q.men;
        end
        M_RIS: begin
          s_d.rdata[NMOD-1:0] = status_view(mod_raw, s_q.men, 1'b0);
        end
        M_MIS: begin
          s_d.rdata[NMOD-1:0] = status_view(mod_raw, s_q.men, 1'b1);
        end
        M_FSUP: begin
          s_d.rdata[NOUT-1:0] = s_q.sup;
        end
        M_FLVL: begin
          s_d.rdata[NOUT-1:0] = s_q.lvl;
        end
        M_INV: begin
          s_d.rdata[NOUT-1:0] = s_q.inv;
        end
        M_EXTF: begin
          s_d.rdata[0] = s_q.ext;
        end
        default: begin
          s_d.rdata = RD_ZERO;
        end
      endcase
    end
  end

  // State register with synchronous reset; everything off after reset.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s_q <= '{men: '0, fris: '0, sup: OUT_RST, lvl: OUT_RST,
               inv: OUT_RST, ext: 1'b0, rdata: RD_ZERO, irq: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign rdata   = s_q.rdata;
  assign mod_irq = s_q.irq;

  // module irq
  // Generator bits arrive a cycle late because gen_irq is itself registered.
  AST_MOD_IRQ: assert property (@(posedge clk) disable iff (!rst_b)
    mod_irq == |({s_q.fris, $past(gen_irq)} & s_q.men))
    else $error("module irq disagrees with masked status");

  AST_FLT_IRQ: assert property (@(posedge clk) disable iff (!rst_b)
    (fault_in[0] && s_q.men[FLT_LSB] && !wr) |=> mod_irq)
    else $error("enabled fault did not raise module irq");

  AST_PER_READ: assert property (@(posedge clk) disable iff (!rst_b)
    (rd && in_gen && goff == G_PER) |=> (rdata[PERW-1:0] == g_pend[$past(gsel)]))
    else $error("period read not programmed value");

  AST_PER_WR: assert property (@(posedge clk) disable iff (!rst_b)
    (wr && in_gen && goff == G_PER) |=> (g_pend[$past(gsel)] == $past(wdata[PERW-1:0])))
    else $error("pending period not the last write");

  AST_EN_READ: assert property (@(posedge clk) disable iff (!rst_b)
    (rd && in_gen && goff == G_EN) |=> (rdata[NEN-1:0] == $past(g_en[gsel])))
    else $error("generator enable read wrong");

  AST_GRIS_READ: assert property (@(posedge clk) disable iff (!rst_b)
    (rd && in_gen && goff == G_RIS) |=> (rdata[NEVT-1:0] == $past(g_ris[gsel])))
    else $error("generator raw status read wrong");

  AST_GMIS_READ: assert property (@(posedge clk) disable iff (!rst_b)
    (rd && in_gen && goff == G_MIS) |=> (rdata[NEVT-1:0] == $past(g_ris[gsel] & g_en[gsel][NEVT-1:0])))
    else $error("generator masked status read wrong");

  AST_MEN_SET: assert property (@(posedge clk) disable iff (!rst_b)
    (wr && !in_gen && moff == M_EN_SET) |=> ((s_q.men & $past(wdata[NMOD-1:0])) == $past(wdata[NMOD-1:0])))
    else $error("module enable set lost");

  AST_MEN_CLR: assert property (@(posedge clk) disable iff (!rst_b)
    (wr && !in_gen && moff == M_EN_CLR) |=> ((s_q.men & $past(wdata[NMOD-1:0])) == '0))
    else $error("module enable clear lost");

  AST_MEN_READ: assert property (@(posedge clk) disable iff (!rst_b)
    (rd && !in_gen && moff == M_EN) |=> (rdata[NMOD-1:0] == $past(s_q.men)))
    else $error("module enable read wrong");

  AST_RIS_READ: assert property (@(posedge clk) disable iff (!rst_b)
    (rd && !in_gen && moff == M_RIS) |=> (rdata[NMOD-1:0] == $past({s_q.fris, gen_irq})))
    else $error("module raw status read wrong");

  AST_MIS_READ: assert property (@(posedge clk) disable iff (!rst_b)
    (rd && !in_gen && moff == M_MIS) |=> (rdata[NMOD-1:0] == $past({s_q.fris, gen_irq} & s_q.men)))
    else $error("module masked status read wrong");

  // fault status held
  // A write-one clear in the next cycle may drop the bit legally.
  AST_FAULT_STICKY: assert property (@(posedge clk) disable iff (!rst_b)
    fault_in[0] |=> s_q.fris[0] ##1 (s_q.fris[0] || $past(wr && !in_gen && moff == M_RIS && wdata[FLT_LSB])))
    else $error("fault status not held");

  AST_FLT_CLR: assert property (@(posedge clk) disable iff (!rst_b)
    (wr && !in_gen && moff == M_RIS && wdata[FLT_LSB] && !fault_in[0]) |=> !s_q.fris[0])
    else $error("fault status not cleared");

  AST_SUP_WR: assert property (@(posedge clk) disable iff (!rst_b)
    (wr && !in_gen && moff == M_FSUP) |=> (s_q.sup == $past(wdata[NOUT-1:0])))
    else $error("suppress select not written");

  AST_LVL_WR: assert property (@(posedge clk) disable iff (!rst_b)
    (wr && !in_gen && moff == M_FLVL) |=> (s_q.lvl == $past(wdata[NOUT-1:0])))
    else $error("level select not written");

  AST_INV_WR: assert property (@(posedge clk) disable iff (!rst_b)
    (wr && !in_gen && moff == M_INV) |=> (s_q.inv == $past(wdata[NOUT-1:0])))
    else $error("inversion select not written");

  AST_EXT_WR: assert property (@(posedge clk) disable iff (!rst_b)
    (wr && !in_gen && moff == M_EXTF) |=> (s_q.ext == $past(wdata[0])))
    else $error("extended handling not written");

endmodule : pic_top

// file: pic_pkg.sv
// Shared constants, register map and helpers for the PWM interrupt, fault and output control slice.
package pic_pkg;

  localparam int NGEN        = 4;  // Generators.
  localparam int NOUT        = 8;  // Outputs.
  localparam int OUT_PER_GEN = 2;  // Outputs owned by one generator.
  localparam int NEVT        = 6;  // Interrupt sources per generator.
  localparam int NTRG        = 4;  // Trigger sources per generator.
  localparam int NEN         = 10; // Enable bits per generator.
  localparam int NMOD        = 8;  // Module status bits.
  localparam int PERW        = 16; // Period width in PWM clock ticks.
  localparam int DW          = 32;
  localparam int AW          = 8;

  // Event input positions, also the status bit positions.
  localparam int EV_ZERO = 0;
  localparam int EV_LOAD = 1;
  localparam int EV_AU   = 2;
  localparam int EV_AD   = 3;
  localparam int EV_BU   = 4;
  localparam int EV_BD   = 5;
  // Enable bits 0..5 follow the events; triggers start here.
  localparam int TRG_LSB = 6;
  // Module status: generators in the low nibble, faults above.
  localparam int FLT_LSB = 4;

  // Address split: bit 7 picks the generator region.
  localparam int GREG_BIT = 7;
  localparam int GSEL_LSB = 5;
  localparam int GSEL_W   = 2;
  localparam int GOFF_W   = 5;
  localparam int MOFF_W   = 7;

  // Generator register offsets inside a 32-byte window.
  localparam logic [GOFF_W-1:0] G_EN_SET = 5'h00;
  localparam logic [GOFF_W-1:0] G_EN_CLR = 5'h04;
  localparam logic [GOFF_W-1:0] G_EN     = 5'h08;
  localparam logic [GOFF_W-1:0] G_RIS    = 5'h0c;
  localparam logic [GOFF_W-1:0] G_MIS    = 5'h10;
  localparam logic [GOFF_W-1:0] G_PER    = 5'h14;
  // Module register offsets.
  localparam logic [MOFF_W-1:0] M_EN_SET = 7'h00;
  localparam logic [MOFF_W-1:0] M_EN_CLR = 7'h04;
  localparam logic [MOFF_W-1:0] M_EN     = 7'h08;
  localparam logic [MOFF_W-1:0] M_RIS    = 7'h0c;
  localparam logic [MOFF_W-1:0] M_MIS    = 7'h10;
  localparam logic [MOFF_W-1:0] M_FSUP   = 7'h14;
  localparam logic [MOFF_W-1:0] M_FLVL   = 7'h18;
  localparam logic [MOFF_W-1:0] M_INV    = 7'h1c;
  localparam logic [MOFF_W-1:0] M_EXTF   = 7'h20;

  // Reset values.
  localparam logic [NEN-1:0]  EN_RST  = 10'h000;
  localparam logic [NEVT-1:0] RIS_RST = 6'h00;
  localparam logic [PERW-1:0] PER_RST = 16'h0000;
  localparam logic [NOUT-1:0] OUT_RST = 8'h00;
  localparam logic [DW-1:0]   RD_ZERO = 32'h0000_0000;

  // Raw or enable-masked view of a status field.
  function automatic logic [NMOD-1:0] status_view(logic [NMOD-1:0] raw,
                                                  logic [NMOD-1:0] en,
                                                  logic status_masked_select);
    status_view = status_masked_select ? (raw & en) : raw;
  endfunction : status_view

  // Generator index carried by a register address.
  function automatic logic [GSEL_W-1:0] gen_of(logic [AW-1:0] a);
    gen_of = a[GSEL_LSB +: GSEL_W];
  endfunction : gen_of

endpackage : pic_pkg

// file: pic_gen.sv
// One generator: enable mask, sticky status, interrupt and trigger, buffered period.
module pic_gen
  import pic_pkg::*;
(
  input  wire logic            clk,
  input  wire logic            rst_b,
  input  wire logic [NEVT-1:0] evt,
  input  wire logic            en_set,
  input  wire logic            en_clr,
  input  wire logic            ris_clr,
  input  wire logic            per_wr,
  input  wire logic [DW-1:0]   wdata,
  output logic      [NEN-1:0]  en,
  output logic      [NEVT-1:0] ris,
  output logic                 irq,
  output logic                 trig,
  output logic      [PERW-1:0] per_pend,
  output logic      [PERW-1:0] per_act
);

  typedef struct packed {
    logic [NEN-1:0]  en;
    logic [NEVT-1:0] ris;
    logic            irq;
    logic            trig;
    logic [PERW-1:0] pend;
    logic            pend_vld;
    logic [PERW-1:0] act;
  } pic_gen_s;

  pic_gen_s s_q;
  pic_gen_s s_d;
  logic [NTRG-1:0] trg_src;

  // Next state of the whole generator slice.
  always_comb begin
    s_d = s_q;
    trg_src = {evt[EV_BD], evt[EV_BU], evt[EV_LOAD], evt[EV_ZERO]};
    if (en_set) begin
      s_d.en = s_q.en | wdata[NEN-1:0];
    end
    if (en_clr) begin
      s_d.en = s_q.en & ~wdata[NEN-1:0];
    end
    // write one clears
    // A new event in the clearing cycle survives, so no edge is lost.
    s_d.ris = (s_q.ris & ~(ris_clr ? wdata[NEVT-1:0] : RIS_RST)) | evt;
    s_d.irq = |(s_d.ris & s_d.en[NEVT-1:0]);
    s_d.trig = |(trg_src & s_q.en[TRG_LSB +: NTRG]);
    if (per_wr) begin
      s_d.pend = wdata[PERW-1:0];
      s_d.pend_vld = 1'b1;
    end
    // apply at zero
    // A write in the zero cycle waits for the next zero.
    if (evt[EV_ZERO] && s_q.pend_vld) begin
      s_d.act = s_q.pend;
      s_d.pend_vld = per_wr;
    end
  end

  // State register with synchronous reset.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s_q <= '{en: EN_RST, ris: RIS_RST, irq: 1'b0, trig: 1'b0,
               pend: PER_RST, pend_vld: 1'b0, act: PER_RST};
    end else begin
      s_q <= s_d;
    end
  end

  assign en       = s_q.en;
  assign ris      = s_q.ris;
  assign irq      = s_q.irq;
  assign trig     = s_q.trig;
  assign per_pend = s_q.pend;
  assign per_act  = s_q.act;

  AST_EN_SET: assert property (@(posedge clk) disable iff (!rst_b)
    en_set |=> ((en & $past(wdata[NEN-1:0])) == $past(wdata[NEN-1:0])))
    else $error("enable set lost");
  AST_EN_CLR: assert property (@(posedge clk) disable iff (!rst_b)
    en_clr |=> ((en & $past(wdata[NEN-1:0])) == EN_RST))
    else $error("enable clear lost");
  AST_W1C: assert property (@(posedge clk) disable iff (!rst_b)
    (ris_clr && ((wdata[NEVT-1:0] & evt) == RIS_RST)) |=> ((ris & $past(wdata[NEVT-1:0])) == RIS_RST))
    else $error("status not cleared");
  AST_IRQ_MASK: assert property (@(posedge clk) disable iff (!rst_b)
    irq == |(ris & en[NEVT-1:0]))
    else $error("irq disagrees with masked status");
  AST_PER_APPLY: assert property (@(posedge clk) disable iff (!rst_b)
    (evt[EV_ZERO] && s_q.pend_vld) |=> (per_act == $past(per_pend)))
    else $error("period not applied at zero");

endmodule : pic_gen

// file: pic_outs.sv
// Output stage: inversion and fault suppression for all outputs.
module pic_outs
  import pic_pkg::*;
(
  input  wire logic            clk,
  input  wire logic            rst_b,
  input  wire logic [NOUT-1:0] wave,
  input  wire logic [NGEN-1:0] gen_fault,
  input  wire logic [NOUT-1:0] sup,
  input  wire logic [NOUT-1:0] lvl,
  input  wire logic [NOUT-1:0] inv,
  input  wire logic            ext,
  output logic      [NOUT-1:0] pwm_out
);

  typedef struct packed {
    logic [NOUT-1:0] out;
  } pic_outs_s;

  pic_outs_s s_q;
  pic_outs_s s_d;

  // Fault overrides the inverted waveform, so the level is the pin level.
  always_comb begin
    s_d = s_q;
    for (int i = 0; i < NOUT; i++) begin
      if (sup[i] && gen_fault[i / OUT_PER_GEN]) begin
        s_d.out[i] = ext & lvl[i];
      end else begin
        s_d.out[i] = wave[i] ^ inv[i];
      end
    end
  end

  // Output register keeps the pins glitch free.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s_q <= '{out: OUT_RST};
    end else begin
      s_q <= s_d;
    end
  end

  assign pwm_out = s_q.out;

  AST_SUP_LEVEL: assert property (@(posedge clk) disable iff (!rst_b)
    (sup[0] && gen_fault[0]) |=> (pwm_out[0] == $past(ext & lvl[0])))
    else $error("suppressed level wrong");
  AST_PASS: assert property (@(posedge clk) disable iff (!rst_b)
    !sup[1] |=> (pwm_out[1] == $past(wave[1] ^ inv[1])))
    else $error("unsuppressed output altered");
  AST_LOW_NOEXT: assert property (@(posedge clk) disable iff (!rst_b)
    (!ext && sup[2] && gen_fault[1]) |=> !pwm_out[2])
    else $error("suppressed output not low");

endmodule : pic_outs

// file: pic_top_tb.sv
// Self-checking testbench for the PWM interrupt, fault and output control slice.
module pic_top_tb import pic_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  logic                      clk = 1'b0;
  logic                      rst_b = 1'b0;
  logic [AW-1:0]             addr = 8'h00;
  logic [DW-1:0]             wdata = 32'h0;
  logic                      wr = 1'b0;
  logic                      rd = 1'b0;
  logic [DW-1:0]             rdata;
  logic [NGEN-1:0][NEVT-1:0] gen_evt = '0;
  logic [NGEN-1:0]           gen_fault = 4'h0;
  logic [NGEN-1:0]           fault_in = 4'h0;
  logic [NOUT-1:0]           wave = 8'h00;
  logic [NGEN-1:0]           gen_irq;
  logic [NGEN-1:0]           gen_trig;
  logic [NGEN-1:0][PERW-1:0] period_active;
  logic                      mod_irq;
  logic [NOUT-1:0]           pwm_out;
  int                        fail_count = 0;
  int                        cmp_count = 0;

  // Registers that must read zero after reset; the last two are unmapped.
  localparam logic [AW-1:0] RST_A [8] = '{{1'b1, 2'h0, G_EN}, {1'b1, 2'h3, G_PER}, {1'b0, M_EN},
    {1'b0, M_FSUP}, {1'b0, M_INV}, {1'b0, M_EXTF}, 8'h7c, 8'h9c};

  pic_top uut (.clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .gen_evt(gen_evt), .gen_fault(gen_fault), .fault_in(fault_in), .wave(wave), .gen_irq(gen_irq),
    .gen_trig(gen_trig), .period_active(period_active), .mod_irq(mod_irq), .pwm_out(pwm_out));

  // Free-running 100 MHz clock.
  always #5 clk = ~clk;

  // Compares for register reads and for pin levels.
  task automatic chk_rd(input logic [DW-1:0] got, input logic [DW-1:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected read at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk_rd

  task automatic chk_pin(input logic [DW-1:0] got, input logic [DW-1:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected pin at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk_pin

  // Bus cycles end one edge later so strobes never get two assignments in one step.
  task automatic wr_reg(input logic [AW-1:0] a, input logic [DW-1:0] d);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask : wr_reg

  task automatic rd_chk(input logic [AW-1:0] a, input logic [DW-1:0] exp);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk_rd(rdata, exp);
    @(posedge clk);
  endtask : rd_chk

  function automatic logic [AW-1:0] ga(input int g, input logic [GOFF_W-1:0] off);
    ga = {1'b1, 2'(g), off};
  endfunction : ga

  function automatic logic [AW-1:0] ma(input logic [MOFF_W-1:0] off);
    ma = {1'b0, off};
  endfunction : ma

  // Pin model: suppression wins over the inverted waveform, level only with extended handling.
  function automatic logic [NOUT-1:0] exp_out(logic [NOUT-1:0] w, logic [NGEN-1:0] f, logic [NOUT-1:0] s,
                                              logic [NOUT-1:0] l, logic [NOUT-1:0] v, logic x);
    for (int i = 0; i < NOUT; i++) begin
      exp_out[i] = (s[i] & f[i/2]) ? (x & l[i]) : (w[i] ^ v[i]);
    end
  endfunction : exp_out

  function automatic int exp_trig(logic [NEN-1:0] en, logic [NEVT-1:0] e);
    exp_trig = int'(|(en[NEN-1:TRG_LSB] & {e[EV_BD], e[EV_BU], e[EV_LOAD], e[EV_ZERO]}));
  endfunction : exp_trig

  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : results

  // Main sequence.
  initial begin : main
    logic [NEN-1:0]  en_v [NGEN];
    logic [NEVT-1:0] ev_v [NGEN];
    logic [NEN-1:0]  s1, s2, c;
    logic [NGEN-1:0] girq, fr, gf;
    logic [NMOD-1:0] men;
    logic [NOUT-1:0] sup, lvl, inv, w;
    logic [PERW-1:0] p1, p2;
    int              tc;
    void'($urandom(54804));
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    foreach (RST_A[k]) rd_chk(RST_A[k], RD_ZERO);
    chk_pin(DW'({gen_irq, mod_irq, pwm_out}), RD_ZERO);
    // Generator masks and events; generator 0 exercises every source, generator 1 masks all.
    girq = 4'h0;
    for (int g = 0; g < NGEN; g++) begin
      s1 = (g == 0) ? 10'h3ff : NEN'($urandom);
      s2 = NEN'($urandom);
      c = (g == 0) ? 10'h000 : (g == 1) ? 10'h3ff : NEN'($urandom);
      wr_reg(ga(g, G_EN_SET), DW'(s1));
      wr_reg(ga(g, G_EN_SET), DW'(s2));
      rd_chk(ga(g, G_EN), DW'(s1 | s2));
      wr_reg(ga(g, G_EN_CLR), DW'(c));
      en_v[g] = (s1 | s2) & ~c;
      rd_chk(ga(g, G_EN), DW'(en_v[g]));
      ev_v[g] = (g < 2) ? 6'h3f : NEVT'($urandom);
      gen_evt[g] <= ev_v[g];
      @(posedge clk);
      gen_evt[g] <= 6'h00;
      tc = 0;
      repeat (4) begin
        #1;
        tc += int'(gen_trig[g] === 1'b1);
        @(posedge clk);
      end
      chk_pin(DW'(tc), DW'(exp_trig(en_v[g], ev_v[g])));
      girq[g] = |(ev_v[g] & en_v[g][NEVT-1:0]);
      chk_pin(DW'(gen_irq[g]), DW'(girq[g]));
      rd_chk(ga(g, G_RIS), DW'(ev_v[g]));
      rd_chk(ga(g, G_MIS), DW'(ev_v[g] & en_v[g][NEVT-1:0]));
    end
    // Module enables, raw and masked status, sticky faults.
    men = NMOD'($urandom) | 8'h11;
    wr_reg(ma(M_EN_SET), 32'hffff_ffff);
    wr_reg(ma(M_EN_CLR), DW'(~men));
    rd_chk(ma(M_EN), DW'(men));
    fr = NGEN'($urandom) | 4'h1;
    fault_in <= fr;
    @(posedge clk);
    fault_in <= 4'h0;
    @(posedge clk);
    rd_chk(ma(M_RIS), DW'({fr, girq}));
    rd_chk(ma(M_MIS), DW'({fr, girq} & men));
    chk_pin(DW'(mod_irq), DW'(|({fr, girq} & men)));
    wr_reg(ma(M_RIS), 32'h0000_00f0);
    rd_chk(ma(M_RIS), DW'({4'h0, girq}));
    for (int g = 0; g < NGEN; g++) begin
      wr_reg(ga(g, G_RIS), DW'(ev_v[g]));
      rd_chk(ga(g, G_RIS), RD_ZERO);
      chk_pin(DW'(gen_irq[g]), RD_ZERO);
    end
    chk_pin(DW'(mod_irq), RD_ZERO);
    // Buffered period: two writes, read-back of the latest, transfer at counter zero.
    for (int g = 0; g < NGEN; g++) begin
      p1 = PERW'($urandom);
      p2 = PERW'($urandom) | 16'h0001;
      wr_reg(ga(g, G_PER), DW'(p1));
      wr_reg(ga(g, G_PER), DW'(p2));
      rd_chk(ga(g, G_PER), DW'(p2));
      chk_pin(DW'(period_active[g]), RD_ZERO);
      gen_evt[g] <= 6'h01;
      @(posedge clk);
      gen_evt[g] <= 6'h00;
      repeat (2) @(posedge clk);
      #1;
      chk_pin(DW'(period_active[g]), DW'(p2));
      @(posedge clk);
    end
    // Output stage with and without extended fault handling; first cycle faults every generator.
    // Output 1 stays unsuppressed so the pass-through path runs under faults.
    sup = (NOUT'($urandom) | 8'h0d) & 8'hfd;
    lvl = NOUT'($urandom) | 8'hf0;
    inv = NOUT'($urandom);
    wr_reg(ma(M_FSUP), DW'(sup));
    wr_reg(ma(M_FLVL), DW'(lvl));
    wr_reg(ma(M_INV), DW'(inv));
    rd_chk(ma(M_FLVL), DW'(lvl));
    rd_chk(ma(M_FSUP), DW'(sup));
    rd_chk(ma(M_INV), DW'(inv));
    for (int x = 0; x < 2; x++) begin
      wr_reg(ma(M_EXTF), DW'(x));
      rd_chk(ma(M_EXTF), DW'(x));
      for (int i = 0; i < 32; i++) begin
        w = NOUT'($urandom);
        gf = (i == 0) ? 4'hf : NGEN'($urandom);
        wave <= w;
        gen_fault <= gf;
        @(posedge clk);
        #1;
        chk_pin(DW'(pwm_out), DW'(exp_out(w, gf, sup, lvl, inv, 1'(x))));
        @(posedge clk);
      end
    end
    results();
  end

  // Guard against a hung sequence.
  initial begin : watchdog
    repeat (20000) @(posedge clk);
    fail_count++;
    $display("unexpected timeout at %0t: sequence did not finish", $time);
    results();
  end

endmodule : pic_top_tb
